/* rtl/itt_consts.svh */
// offsets, field positions, reset values and prescaler widths of the timer
`ifndef ITT_CONSTS_SVH
`define ITT_CONSTS_SVH
// register indices; the byte address is four times the index, and only
// its low byte is decoded, so the block aliases across the address space
`define ITT_IDX_MODE      16'hFFB0
`define ITT_IDX_COUNT     16'hFFB1
`define ITT_OFF_MODE      8'hC0
`define ITT_OFF_COUNT     8'hC4
`define ITT_OFF_STATUS    8'hC8
`define ITT_OFF_MASK      8'hCC
`define ITT_OFF_PMODE     8'hD0
`define ITT_MODE_RESET    8'h10
`define ITT_MODE_FIXED    8'h10
`define ITT_COUNT_RESET   8'h00
`define ITT_BIT_TBASE     3
`define ITT_BIT_CLEAR     2
`define ITT_OSEL_LSB      5
`define ITT_WPS_W         15
`define ITT_PSS_W         13
`endif

/* rtl/itt_pkg.sv */
// types shared by the timer design
package itt_pkg;
    typedef enum logic [1:0] {
        ITT_PWR_ACTIVE,
        ITT_PWR_SLEEP,
        ITT_PWR_SUB,
        ITT_PWR_STOP
    } itt_pwr_e;
    typedef enum logic [1:0] {
        ITT_BUS_IDLE,
        ITT_BUS_WRITE,
        ITT_BUS_READ
    } itt_bus_e;
endpackage

/* rtl/itt_timer.sv */
// interval and time-base timer with clock output, AHB-Lite slave
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "itt_consts.svh"

// Contract
// - count each selected tick; FF wrap flags overflow
// - interrupt only while overflow enable is one
// - interval mode wraps to 00, 256 ticks
// - mode 0 selects one of eight system taps
// - mode 1 selects four watch overflow periods
// - select pattern 11 holds counter, watch prescaler clear
// - output select picks system or watch divide
// - drive clock pin only when output enabled
// - system output only active/sleep; watch also sub
// - reset: mode 10, count 00, counting starts
// - mode bit four reads one, ignores writes
// - interval count halts outside active and sleep
// - time-base count halts only in stop mode
// - watch tick synchronised to system clock
module itt_timer
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        watch_clk,
    input  wire logic [1:0]  power_mode,
    output logic             divided_clock_out,
    output logic             divided_clock_out_oe,
    output logic             irq
);

    // =====================================================
    // state
    // =====================================================
    logic [7:0]  mode_ff, nxt_mode;
    logic [7:0]  count_ff, nxt_count;
    logic        flag_ff, nxt_flag;
    logic        ena_ff, nxt_ena;
    logic        pmode_ff, nxt_pmode;
    logic [`ITT_PSS_W-1:0] pss_ff, nxt_pss;
    logic [`ITT_WPS_W-1:0] wps_ff, nxt_wps;
    logic [2:0]  wsync_ff, nxt_wsync;
    logic        wtick_ff, nxt_wtick;
    logic [31:0] rdata_ff, nxt_rdata;
    logic        irq_ff, nxt_irq;
    logic        tmo_ff, nxt_tmo;
    logic        tmo_oe_ff, nxt_tmo_oe;
    itt_pkg::itt_bus_e bus_ff, nxt_bus;
    logic [7:0]  addr_ff, nxt_addr;

    // bit of a free-running counter that toggles at the given divide
    function automatic logic [3:0] itt_sys_tap(input logic [2:0] sel);
        case (sel)
            3'h0:    itt_sys_tap = 4'hC;
            3'h1:    itt_sys_tap = 4'hB;
            3'h2:    itt_sys_tap = 4'hA;
            3'h3:    itt_sys_tap = 4'h8;
            3'h4:    itt_sys_tap = 4'h7;
            3'h5:    itt_sys_tap = 4'h6;
            3'h6:    itt_sys_tap = 4'h4;
            default: itt_sys_tap = 4'h2;
        endcase
    endfunction

    // falling edge of a prescaler bit marks one full tap period
    function automatic logic itt_fall(input logic [15:0] a,
                                      input logic [15:0] b,
                                      input logic [3:0] bit_i);
        itt_fall = a[bit_i] & ~b[bit_i];
    endfunction

    // =====================================================
    // bus decode
    // =====================================================
    logic take;
    logic [7:0] wbyte;
    logic pss_tick, wps_tick, cnt_tick, cleared, tbase, run_ok;
    logic [3:0] wbit;
    logic sys_ok, w_ok, out_sel;

    always_comb
    begin
        take = hsel & hready & htrans[1];
        wbyte = hwdata[7:0];
        tbase = mode_ff[`ITT_BIT_TBASE];
        cleared = tbase & mode_ff[`ITT_BIT_CLEAR];
        // watch/128 tick into an 8-bit counter gives 1 s: bit 6 of the
        // watch prescaler falls every 128 watch cycles; watch/4 is bit 1
        case (mode_ff[1:0])
            2'h0:    wbit = 4'h6;
            2'h1:    wbit = 4'h5;
            2'h2:    wbit = 4'h4;
            default: wbit = 4'h1;
        endcase
        pss_tick = itt_fall(16'(pss_ff), 16'(nxt_pss),
                            itt_sys_tap(mode_ff[2:0]));
        // watch tick is the synchronised edge, never the raw pin
        wps_tick = wtick_ff;
        sys_ok = (power_mode == 2'(itt_pkg::ITT_PWR_ACTIVE)) ||
                 (power_mode == 2'(itt_pkg::ITT_PWR_SLEEP));
        w_ok = power_mode != 2'(itt_pkg::ITT_PWR_STOP);
        run_ok = tbase ? w_ok : sys_ok;
        cnt_tick = run_ok & (tbase ? (wps_tick & itt_fall(16'(wps_ff),
                   16'(wps_ff + 1'b1), wbit)) : pss_tick);
        out_sel = mode_ff[7];
    end

    // =====================================================
    // next-state of counters and synchroniser
    // =====================================================
    always_comb
    begin
        nxt_pss = pss_ff + 1'b1;
        // wsync[0] feeds wsync[1] only; edge taken on wsync[2:1]
        nxt_wsync = {wsync_ff[1:0], watch_clk};
        nxt_wtick = wsync_ff[1] & ~wsync_ff[2];
        nxt_wps = wps_ff;
        if (cleared)
            nxt_wps = '0;
        else if (wtick_ff && w_ok)
            nxt_wps = wps_ff + 1'b1;
        nxt_count = count_ff;
        if (cleared)
            nxt_count = `ITT_COUNT_RESET;
        else if (cnt_tick)
            nxt_count = count_ff + 8'h01;
    end

    // =====================================================
    // registers, flag, interrupt and pin
    // =====================================================
    always_comb
    begin
        nxt_bus = itt_pkg::ITT_BUS_IDLE;
        nxt_addr = addr_ff;
        if (take)
        begin
            nxt_bus = hwrite ? itt_pkg::ITT_BUS_WRITE : itt_pkg::ITT_BUS_READ;
            nxt_addr = haddr[7:0];
        end
        nxt_mode = mode_ff;
        nxt_ena = ena_ff;
        nxt_pmode = pmode_ff;
        nxt_flag = flag_ff;
        if (bus_ff == itt_pkg::ITT_BUS_WRITE)
        begin
            case (addr_ff)
                `ITT_OFF_MODE:   nxt_mode = wbyte | `ITT_MODE_FIXED;
                `ITT_OFF_STATUS: nxt_flag = flag_ff & ~wbyte[0];
                `ITT_OFF_MASK:   nxt_ena = wbyte[0];
                `ITT_OFF_PMODE:  nxt_pmode = wbyte[0];
                default:         nxt_mode = mode_ff;
            endcase
        end
        // set wins over a clearing write in the same cycle
        if (cnt_tick && count_ff == 8'hFF)
            nxt_flag = 1'b1;
        nxt_rdata = 32'h0000_0000;
        if (take && !hwrite)
        begin
            case (haddr[7:0])
                `ITT_OFF_MODE:   nxt_rdata = {24'h0, mode_ff};
                `ITT_OFF_COUNT:  nxt_rdata = {24'h0, count_ff};
                `ITT_OFF_STATUS: nxt_rdata = {31'h0, flag_ff};
                `ITT_OFF_MASK:   nxt_rdata = {31'h0, ena_ff};
                `ITT_OFF_PMODE:  nxt_rdata = {31'h0, pmode_ff};
                default:         nxt_rdata = 32'h0000_0000;
            endcase
        end
        nxt_irq = nxt_flag & nxt_ena;
        // divide by 32..4 from prescaler bits 4..1
        nxt_tmo = out_sel
                ? wps_ff[3'h4 - 3'(mode_ff[6:5])]
                : pss_ff[3'h4 - 3'(mode_ff[6:5])];
        nxt_tmo_oe = pmode_ff & (out_sel ? w_ok && power_mode !=
                     2'(itt_pkg::ITT_PWR_STOP) : sys_ok);
        if (out_sel && !(sys_ok || power_mode ==
            2'(itt_pkg::ITT_PWR_SUB)))
            nxt_tmo_oe = 1'b0;
        // gate before the flop so the pin comes straight from a register
        nxt_tmo = nxt_tmo & nxt_tmo_oe;
    end

    // reset values give interval mode at slowest tap, running at once
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mode_ff   <= `ITT_MODE_RESET;
            count_ff  <= `ITT_COUNT_RESET;
            flag_ff   <= 1'b0;
            ena_ff    <= 1'b0;
            pmode_ff  <= 1'b0;
            pss_ff    <= '0;
            wps_ff    <= '0;
            wsync_ff  <= 3'h0;
            wtick_ff  <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            irq_ff    <= 1'b0;
            tmo_ff    <= 1'b0;
            tmo_oe_ff <= 1'b0;
            bus_ff    <= itt_pkg::ITT_BUS_IDLE;
            addr_ff   <= 8'h00;
        end
        else
        begin
            mode_ff   <= nxt_mode;
            count_ff  <= nxt_count;
            flag_ff   <= nxt_flag;
            ena_ff    <= nxt_ena;
            pmode_ff  <= nxt_pmode;
            pss_ff    <= nxt_pss;
            wps_ff    <= nxt_wps;
            wsync_ff  <= nxt_wsync;
            wtick_ff  <= nxt_wtick;
            rdata_ff  <= nxt_rdata;
            irq_ff    <= nxt_irq;
            tmo_ff    <= nxt_tmo;
            tmo_oe_ff <= nxt_tmo_oe;
            bus_ff    <= nxt_bus;
            addr_ff   <= nxt_addr;
        end
    end

    // zero-wait slave, always OKAY
    assign hrdata = rdata_ff;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign divided_clock_out = tmo_ff;
    assign divided_clock_out_oe = tmo_oe_ff;
    assign irq = irq_ff;

endmodule
`default_nettype wire

/* test/itt_timer_properties.sv */
// checker: timing rules of the timer outputs against its bus traffic
`timescale 1ns/1ps
`default_nettype none
`include "itt_consts.svh"
module itt_timer_checker
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic [1:0]  power_mode,
    input wire logic        divided_clock_out,
    input wire logic        divided_clock_out_oe,
    input wire logic        irq
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ==========================================================
    // shadow of written registers; outputs may lag it by two edges
    logic       ap_ff, aw_ff, msk_ff, oe_ff;
    logic [7:0] aa_ff, mode_ff;
    wire logic  ap  = hsel && hready && htrans[1];
    wire logic  dw  = ap_ff && aw_ff;
    wire logic  wsc = dw && (aa_ff == `ITT_OFF_STATUS || aa_ff == `ITT_OFF_MASK);
    wire logic  rdm = ap && !hwrite && haddr[7:0] == `ITT_OFF_MODE;
    wire logic  rdc = ap && !hwrite && haddr[7:0] == `ITT_OFF_COUNT;
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            {ap_ff, aw_ff, msk_ff, oe_ff, aa_ff} <= '0;
            mode_ff <= `ITT_MODE_RESET;
        end
        else
        begin
            ap_ff <= ap;
            aw_ff <= hwrite;
            aa_ff <= haddr[7:0];
            if (dw && aa_ff == `ITT_OFF_MODE) mode_ff <= hwdata[7:0];
            if (dw && aa_ff == `ITT_OFF_MASK) msk_ff <= hwdata[0];
            if (dw && aa_ff == `ITT_OFF_PMODE) oe_ff <= hwdata[0];
        end
    // ==========================================================
    // properties
    property p_bit4; rdm |=> hrdata[4] && hrdata[31:8] == 24'h0; endproperty
    a_bit4: assert property (p_bit4) else $error("mode bit4 not one");
    property p_rst; $rose(hresetn) |-> hrdata == 32'h0 && !irq; endproperty
    a_rst: assert property (p_rst) else $error("outputs set at reset");
    property p_clr; rdc && mode_ff[3:2] == 2'b11
        && $past(mode_ff[3:2]) == 2'b11 |=> hrdata[7:0] == 8'h00; endproperty
    a_clr: assert property (p_clr) else $error("count not held clear");
    property p_irq; irq |-> msk_ff || $past(msk_ff) || $past(msk_ff, 2);
    endproperty
    a_irq: assert property (p_irq) else $error("irq while masked");
    property p_stk; $fell(irq) |-> $past(wsc) || $past(wsc, 2) || $past(wsc, 3);
    endproperty
    a_stk: assert property (p_stk) else $error("irq dropped alone");
    property p_oe; divided_clock_out_oe |-> oe_ff || $past(oe_ff, 2); endproperty
    a_oe: assert property (p_oe) else $error("pin driven unasked");
    property p_pin; !divided_clock_out_oe |-> !divided_clock_out; endproperty
    a_pin: assert property (p_pin) else $error("pin high undriven");
    property p_sub; (!mode_ff[7] && power_mode == 2'd2)[*3]
        |-> !$rose(divided_clock_out); endproperty
    a_sub: assert property (p_sub) else $error("system clock out in sub");
    c_irq: cover property (irq);
    c_clk: cover property ($rose(divided_clock_out));
    c_clr: cover property (rdc && mode_ff[3:2] == 2'b11);
endmodule
bind itt_timer itt_timer_checker u_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .irq(irq),
    .power_mode(power_mode), .divided_clock_out(divided_clock_out),
    .divided_clock_out_oe(divided_clock_out_oe));
`default_nettype wire

/* test/testbench.sv */
// self-checking bench for the interval timebase timer
`timescale 1ns/1ps
`default_nettype none
`include "itt_consts.svh"
module testbench;
    logic        hclk, hresetn, hsel, hwrite, wclk, hresp, dco, doe, irq, pd;
    logic [31:0] haddr, hwdata, hrdata, r, q;
    logic [1:0]  htrans, pm;
    logic [2:0]  hsize;
    wire logic   hready;
    int          mismatches, samples_checked, edges, e0, c0, cyc;
    int          tp [8] = '{8192, 4096, 2048, 512, 256, 128, 32, 8};
    logic [7:0]  ra [8] = '{`ITT_OFF_MODE, `ITT_OFF_MODE, `ITT_OFF_MODE,
        `ITT_OFF_MASK, `ITT_OFF_PMODE, 8'hE0, `ITT_OFF_COUNT, `ITT_OFF_STATUS};
    logic [7:0]  rw [8] = '{8'hFF, 8'hEF, 8'h00, 8'hFF, 8'hFF, 8'h5A, 8'h77, 8'h01};
    logic [7:0]  re [8] = '{8'hFF, 8'hFF, 8'h10, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
    itt_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
        .watch_clk(wclk), .power_mode(pm), .divided_clock_out(dco),
        .divided_clock_out_oe(doe), .irq(irq));
    // ==========================================================
    // clocks; watch clock is fast and off-phase to keep the run short
    initial
    begin
        hclk = 0;
        forever #4 hclk = ~hclk;
    end
    initial
    begin
        wclk = 0;
        forever #61 wclk = ~wclk;
    end
    // cycle count and rising edges of the clock pin
    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        pd <= dco;
        if (dco && !pd) edges <= edges + 1;
    end
    // run needs about 75000 cycles; stop short of 100000
    initial
    begin
        #760000;
        mismatches++;
        finish_test;
    end
    // ==========================================================
    // bus cycle, compare, clock-pin window and closing
    task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        {hsel, hwrite, htrans, haddr} <= {1'b1, w, 2'h2, 24'h0, a};
        do @(posedge hclk); while (hready !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic win(input logic [7:0] m);
        xf(1, `ITT_OFF_MODE, {24'h0, m});
        repeat (8) @(posedge hclk);
        e0 = edges;
        repeat (128) @(posedge hclk);
    endtask
    task automatic finish_test;
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial
    begin
        {hsel, hwrite, htrans, haddr, hwdata, pm} = '0;
        hsize = 3'h2;
        hresetn = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1;
        xf(0, `ITT_OFF_MODE, 0);
        chk(r, 32'h10);
        for (int i = 0; i < 8; i++)
        begin
            xf(1, ra[i], {24'h0, rw[i]});
            xf(0, ra[i], 0);
            chk(r, {24'h0, re[i]});
        end
        // two reads 2*tap cycles apart see exactly two ticks
        for (int i = 0; i < 8; i++)
        begin
            xf(1, `ITT_OFF_MODE, i);
            xf(0, `ITT_OFF_COUNT, 0);
            q = r;
            repeat (2 * tp[i] - 3) @(posedge hclk);
            xf(0, `ITT_OFF_COUNT, 0);
            chk(8'(r[7:0] - q[7:0]), 32'h2);
        end
        for (int k = 0; k < 2; k++)
        begin
            xf(1, `ITT_OFF_STATUS, 1);
            repeat (3) @(posedge hclk);
            for (int n = 0; n < 2100 && irq !== 1'b1; n++) @(posedge hclk);
            chk(irq, 1);
            if (k == 1) chk(cyc - c0, 2048);
            c0 = cyc;
        end
        repeat (2100) @(posedge hclk);
        xf(1, `ITT_OFF_MASK, 0);
        repeat (3) @(posedge hclk);
        chk(irq, 0);
        xf(0, `ITT_OFF_STATUS, 0);
        chk(r, 1);
        xf(1, `ITT_OFF_STATUS, 1);
        xf(0, `ITT_OFF_STATUS, 0);
        chk(r, 0);
        // count is only read back in active mode
        for (int i = 0; i < 4; i++)
        begin
            xf(1, `ITT_OFF_MODE, i < 2 ? 32'h7 : 32'hB);
            xf(0, `ITT_OFF_COUNT, 0);
            q = r;
            pm <= 2'(2 + i % 2);
            repeat (9150) @(posedge hclk);
            pm <= 0;
            xf(0, `ITT_OFF_COUNT, 0);
            chk(8'(r[7:0] - q[7:0]) > 8'd4, i == 2);
        end
        xf(1, `ITT_OFF_MODE, 32'hC);
        xf(0, `ITT_OFF_COUNT, 0);
        chk(r, 0);
        for (int o = 0; o < 4; o++)
        begin
            win(8'(o << 5));
            chk(edges - e0, 4 << o);
        end
        xf(1, `ITT_OFF_PMODE, 0);
        win(8'h60);
        chk(edges - e0, 0);
        chk(doe, 0);
        xf(1, `ITT_OFF_PMODE, 1);
        pm <= 2;
        win(8'h60);
        chk(edges - e0, 0);
        win(8'hE0);
        chk(edges - e0 > 0, 1);
        // reset in mid-run brings back the reset mode and a quiet irq
        hresetn <= 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1;
        xf(0, `ITT_OFF_MODE, 0);
        chk(r, 32'h10);
        xf(0, `ITT_OFF_COUNT, 0);
        chk(r, 0);
        chk(irq, 0);
        finish_test;
    end
endmodule
`default_nettype wire
